// ### dv/ftx_exc_sig_assertions.sv
// Port-level checks for the transmit exception signalling block
`timescale 1ns/10ps
`default_nettype none

module ftx_exc_sig_assertions #(
    parameter int DATA_W = 32
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic line_tx_clock,
    input wire logic host_fifo_clock,
    input wire logic fifo_write_strobe_n,
    input wire logic tx_side_select_n,
    input wire logic [DATA_W-1:0] tx_word_in,
    input wire logic clear_tx_error,
    input wire logic collision_in,
    input wire logic int_ack,
    input wire logic mii_mode,
    input wire ftx_pkg::ftx_evt_t frame_evt,
    input wire logic tx_retry_flag,
    input wire logic tx_fifo_ready,
    input wire logic line_transmit_enable,
    input wire logic tx_interrupt,
    input wire logic [DATA_W-1:0] tx_word_out,
    input wire logic tx_word_valid
);
    import ftx_pkg::*;
    // One clock domain; every check sleeps through reset
    default clocking dflt_cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    ready_drop_a: assert property ($rose(tx_retry_flag) |-> !tx_fifo_ready)
        else $error("ready still high as retry rose");
    ready_return_a: assert property ($fell(tx_retry_flag) |-> tx_fifo_ready)
        else $error("ready late after retry fell");
    retry_blocks_wr_a: assert property (tx_retry_flag && $past(tx_retry_flag) |-> !tx_word_valid)
        else $error("word taken while retry high");
    // Pin is synchronised, so the flag moves a few cycles after the host clock rise
    retry_host_edge_a: assert property ($changed(tx_retry_flag) |->
        $past(host_fifo_clock, 2) || $past(host_fifo_clock, 3) || $past(host_fifo_clock, 4))
        else $error("retry moved away from a host edge");
    valid_pulse_a: assert property (tx_word_valid |=> !tx_word_valid)
        else $error("valid longer than one cycle");
    underflow_order_a: assert property (frame_evt.underflow && line_transmit_enable |=>
        tx_interrupt ##[0:12] !line_transmit_enable)
        else $error("underflow order wrong");
    done_order_a: assert property ((frame_evt.done || frame_evt.carrier_drop) &&
        line_transmit_enable && !tx_interrupt |=> !line_transmit_enable && !tx_interrupt
        ##[1:12] tx_interrupt)
        else $error("end of frame order wrong");
    collision_in_int_a: assert property ($rose(collision_in) && line_transmit_enable && !mii_mode &&
        !tx_interrupt |-> ##[155:220] tx_interrupt)
        else $error("collision interrupt out of window");
    int_ack_clear_a: assert property ($fell(tx_interrupt) |-> $past(int_ack))
        else $error("interrupt fell without acknowledge");
    int_clear_time_a: assert property ($rose(int_ack) && tx_interrupt |-> ##[8:24] !tx_interrupt)
        else $error("interrupt clear out of window");

    cover property ($rose(tx_retry_flag));
    cover property ($rose(line_transmit_enable));
    cover property ($fell(tx_interrupt));
endmodule
`default_nettype wire

// ### dv/ftx_exc_sig_tb.sv
// Self-checking bench for the transmit exception signalling block
`timescale 1ns/10ps
`default_nettype none

module ftx_exc_sig_tb;
    import ftx_pkg::*;
    localparam int L = 8;
    localparam int H = 6;
    logic ref_clk, line_tx_clock, host_fifo_clock, fifo_write_strobe_n, tx_side_select_n;
    logic clear_tx_error, tx_retry_flag, tx_fifo_ready, line_transmit_enable;
    logic tx_interrupt, tx_word_valid;
    logic rstn = 1'b0;
    logic collision_in = 1'b0;
    logic int_ack = 1'b0;
    logic mii_mode = 1'b0;
    logic wr_req = 1'b0;
    logic clr_req = 1'b0;
    logic [31:0] wr_data = 32'h0;
    logic [31:0] tx_word_in, tx_word_out;
    ftx_evt_t frame_evt = '0;
    int error_cnt = 0;
    int cmp_count = 0;
    int cyc_cnt = 0;
    int seed = 32'hd7437e90;
    int n;

    ftx_host_model u_ftx_host_model (.ref_clk(ref_clk), .rstn(rstn), .wr_req(wr_req),
        .wr_data(wr_data), .clr_req(clr_req), .host_fifo_clock(host_fifo_clock),
        .fifo_write_strobe_n(fifo_write_strobe_n), .tx_side_select_n(tx_side_select_n),
        .tx_word_in(tx_word_in), .clear_tx_error(clear_tx_error));
    ftx_exc_sig #(.DATA_W(32)) u_ftx_exc_sig (.ref_clk(ref_clk), .rstn(rstn),
        .line_tx_clock(line_tx_clock), .host_fifo_clock(host_fifo_clock),
        .fifo_write_strobe_n(fifo_write_strobe_n), .tx_side_select_n(tx_side_select_n),
        .tx_word_in(tx_word_in), .clear_tx_error(clear_tx_error), .collision_in(collision_in),
        .int_ack(int_ack), .mii_mode(mii_mode), .frame_evt(frame_evt),
        .tx_retry_flag(tx_retry_flag), .tx_fifo_ready(tx_fifo_ready),
        .line_transmit_enable(line_transmit_enable), .tx_interrupt(tx_interrupt),
        .tx_word_out(tx_word_out), .tx_word_valid(tx_word_valid));

    // System clock and an unrelated line clock of 400 ns
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    initial begin
        line_tx_clock = 1'b0;
        #37;
        forever #200 line_tx_clock = ~line_tx_clock;
    end
    // Hang guard, far above the few thousand cycles the run needs
    always @(posedge ref_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("errors %0d comparisons %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    // Line-clock tenths converted to system cycles
    function automatic int lc(input int tenths);
        return tenths * L / 10;
    endfunction
    function automatic logic cond(input int s);
        case (s)
            0: return line_transmit_enable === 1'b1;
            1: return tx_interrupt === 1'b1;
            2: return tx_retry_flag === 1'b1;
            3: return tx_retry_flag === 1'b0;
            4: return tx_interrupt === 1'b0;
            default: return tx_word_valid === 1'b1;
        endcase
    endfunction
    // Counts falling edges, where outputs have settled, until the condition holds
    task automatic wait_for(input int s, output int k);
        k = 0;
        do begin
            @(negedge ref_clk);
            k++;
        end while (!cond(s) && k < 400);
    endtask
    task automatic pulse_evt(input ftx_evt_t e);
        @(posedge ref_clk);
        frame_evt <= e;
        @(posedge ref_clk);
        frame_evt <= '0;
    endtask
    task automatic send(input logic [31:0] d);
        @(posedge ref_clk);
        wr_req <= 1'b1;
        wr_data <= d;
        @(posedge ref_clk);
        wr_req <= 1'b0;
    endtask
    task automatic start_tx(output int k);
        logic [31:0] d;
        d = $random(seed);
        send(d);
        wait_for(5, k);
        chk_val(tx_word_out, d);
        wait_for(0, k);
    endtask
    task automatic ack_int();
        int k;
        @(posedge ref_clk);
        int_ack <= 1'b1;
        wait_for(4, k);
        chk_rng(k, lc(15) - 2, lc(25) + 4);
        @(posedge ref_clk);
        int_ack <= 1'b0;
    endtask
    task automatic clear_retry();
        int k;
        @(posedge ref_clk);
        clr_req <= 1'b1;
        @(posedge ref_clk);
        clr_req <= 1'b0;
        wait_for(3, k);
        chk_rng(k, lc(10), lc(20) + 2 * H + 8);
        chk_val(tx_fifo_ready, 1'b1);
    endtask

    // Both line modes: start, collision, underflow, late (serial) or sixteenth (MII) collision, good end (serial) or carrier dropout (MII)
    initial begin
        repeat (6) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        for (int m = 0; m < 2; m++) begin
            mii_mode <= m[0];
            start_tx(n);
            chk_rng(n, (m ? lc(65) : lc(185)) - 4, (m ? lc(85) : lc(265)) + H);
            @(posedge ref_clk);
            collision_in <= 1'b1;
            wait_for(1, n);
            chk_rng(n, (m ? lc(80) : lc(200)) - 4, (m ? lc(90) : lc(270)) + 4);
            @(posedge ref_clk);
            collision_in <= 1'b0;
            ack_int();
            if (!cond(0)) start_tx(n);
            pulse_evt(5'b00100);
            wait_for(2, n);
            chk_rng(n, m ? lc(10) : lc(70), (m ? lc(20) : lc(80)) + 2 * H + 4);
            chk_val(tx_fifo_ready, 1'b0);
            send($random(seed));
            wait_for(5, n);
            chk_rng(n, 400, 400);
            chk_val(tx_retry_flag, 1'b1);
            ack_int();
            clear_retry();
            start_tx(n);
            pulse_evt(m ? 5'b01000 : 5'b10000);
            wait_for(2, n);
            chk_rng(n, m ? lc(70) : lc(250), (m ? lc(100) : lc(340)) + 2 * H + 4);
            clear_retry();
            if (cond(1)) ack_int();
            start_tx(n);
            pulse_evt(m ? 5'b00001 : 5'b00010);
            wait_for(1, n);
            chk_rng(n, 2, lc(20));
            chk_val(line_transmit_enable, 1'b0);
            ack_int();
        end
        // Second reset in mid-run must bring back the idle outputs
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk);
        chk_val({tx_retry_flag, tx_fifo_ready, line_transmit_enable, tx_interrupt}, 4'h4);
        give_verdict();
    end
endmodule

bind ftx_exc_sig ftx_exc_sig_assertions #(.DATA_W(DATA_W)) u_ftx_exc_sig_assertions (
    .ref_clk(ref_clk), .rstn(rstn), .line_tx_clock(line_tx_clock),
    .host_fifo_clock(host_fifo_clock), .fifo_write_strobe_n(fifo_write_strobe_n),
    .tx_side_select_n(tx_side_select_n), .tx_word_in(tx_word_in),
    .clear_tx_error(clear_tx_error), .collision_in(collision_in), .int_ack(int_ack),
    .mii_mode(mii_mode), .frame_evt(frame_evt), .tx_retry_flag(tx_retry_flag),
    .tx_fifo_ready(tx_fifo_ready), .line_transmit_enable(line_transmit_enable),
    .tx_interrupt(tx_interrupt), .tx_word_out(tx_word_out), .tx_word_valid(tx_word_valid));
`default_nettype wire

// ### dv/ftx_host_model.sv
// Host side model: host FIFO clock, write strobe, data and retry clear
`timescale 1ns/10ps
`default_nettype none

module ftx_host_model #(
    parameter int DW = 32
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic wr_req,
    input wire logic [DW-1:0] wr_data,
    input wire logic clr_req,
    output logic host_fifo_clock,
    output logic fifo_write_strobe_n,
    output logic tx_side_select_n,
    output logic [DW-1:0] tx_word_in,
    output logic clear_tx_error
);
    logic [2:0] div_reg;
    logic wr_pend_reg;
    logic clr_pend_reg;
    logic [DW-1:0] data_reg;
    // Host clock at a sixth of ref_clk so the synchroniser never misses an edge
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            div_reg <= 3'h0;
            host_fifo_clock <= 1'b0;
        end else begin
            div_reg <= (div_reg == 3'h5) ? 3'h0 : div_reg + 3'h1;
            host_fifo_clock <= (div_reg < 3'h3);
        end
    end
    // Requests wait for the falling host edge and stand through the next rise
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            wr_pend_reg <= 1'b0;
            clr_pend_reg <= 1'b0;
            data_reg <= '0;
            fifo_write_strobe_n <= 1'b1;
            tx_side_select_n <= 1'b1;
            tx_word_in <= '0;
            clear_tx_error <= 1'b0;
        end else begin
            if (wr_req) begin
                wr_pend_reg <= 1'b1;
                data_reg <= wr_data;
            end else if (div_reg == 3'h3) begin
                wr_pend_reg <= 1'b0;
            end
            clr_pend_reg <= clr_req || (clr_pend_reg && div_reg != 3'h3);
            if (div_reg == 3'h3) begin
                fifo_write_strobe_n <= !wr_pend_reg;
                tx_side_select_n <= !wr_pend_reg;
                // A released bus shows the inverse, never a stale copy
                tx_word_in <= wr_pend_reg ? data_reg : ~tx_word_in;
                clear_tx_error <= clr_pend_reg;
            end
        end
    end
endmodule
`default_nettype wire

// ### hdl/ftx_exc_sig.sv
// Transmit exception signalling: retry flag, FIFO ready, transmit enable, interrupt
//
// Contract
// RL1: A clear pulse drops the retry flag after one line clock plus the next host clock edge.
// RL2: Transmit enable rises a fixed count of line clocks after the first write, per mode.
// RL3: Late or sixteenth collision sets retry after 26 (serial) or 8 (MII) line clocks.
// RL4: Underflow sets retry after 8 (serial) or 2 (MII) line clocks plus a host clock edge.
// RL5: FIFO ready falls in the same cycle that the retry flag rises; here it falls when the set is armed, at least a cycle earlier.
// RL6: FIFO ready returns in the same cycle that the retry flag falls.
// RL7: On underflow the interrupt rises first and transmit enable drops one line clock later.
// RL8: On good end or carrier dropout enable drops first and the interrupt one line clock later.
// RL9: The interrupt rises 21 (serial) or 8 (MII) line clocks after collision input rises.
// RL10: The retry flag changes only on a sampled rising edge of the host FIFO clock.
// RL11: The host writes a word by holding the write strobe low at a host clock rising edge.
// RL12: While retry is high it stays high and no data is taken until the host pulses clear.
// RL13: The interrupt stays high until acknowledged, then clears two line clocks later.
`timescale 1ns/10ps
`default_nettype none
`include "ftx_regs.svh"

module ftx_exc_sig #(
    parameter int DATA_W = 32
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic line_tx_clock,
    input wire logic host_fifo_clock,
    input wire logic fifo_write_strobe_n,
    input wire logic tx_side_select_n,
    input wire logic [DATA_W-1:0] tx_word_in,
    input wire logic clear_tx_error,
    input wire logic collision_in,
    input wire logic int_ack,
    input wire logic mii_mode,
    input wire ftx_pkg::ftx_evt_t frame_evt,
    output logic tx_retry_flag,
    output logic tx_fifo_ready,
    output logic line_transmit_enable,
    output logic tx_interrupt,
    output logic [DATA_W-1:0] tx_word_out,
    output logic tx_word_valid
);
    import ftx_pkg::*;

    localparam int PW = `FTX_PIN_DATA + DATA_W;

    // Elaboration check on the data width
    if (DATA_W < 1 || DATA_W > 64) begin : g_bad_width
        $error("DATA_W must lie between 1 and 64");
    end

    // Pick the mode-dependent count
    function automatic logic [7:0] pick(input logic mii, input logic [7:0] ser,
                                        input logic [7:0] m);
        pick = mii ? m : ser;
    endfunction

    // **********************************************
    // Pin sampling
    // **********************************************
    logic [PW-1:0] pins_raw;
    logic [PW-1:0] pins_s;
    logic [PW-1:0] pins_r;

    assign pins_raw = {tx_word_in, int_ack, fifo_write_strobe_n, tx_side_select_n,
                       clear_tx_error, collision_in, host_fifo_clock, line_tx_clock};

    ftx_pin_sync #(.W(PW)) u_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pin_in(pins_raw),
        .pin_sync(pins_s),
        .pin_rise(pins_r)
    );

    logic txc_tick;
    logic hclk_tick;
    logic collision_in_rise;
    logic ack_rise;
    logic write_seen;

    assign txc_tick = pins_r[`FTX_PIN_TXC];
    assign hclk_tick = pins_r[`FTX_PIN_HCLK];
    assign collision_in_rise = pins_r[`FTX_PIN_COLLISION_IN];
    assign ack_rise = pins_r[`FTX_PIN_ACK];
    // Strobe and select are delayed as much as the clock, so they align at the edge
    assign write_seen = hclk_tick && !pins_s[`FTX_PIN_WR_N] && !pins_s[`FTX_PIN_SEL_N]; // RL11

    // **********************************************
    // Registers
    // **********************************************
    ftx_state_t state_reg;
    ftx_state_t state_next;
    logic retry_reg;
    logic [7:0] start_cnt_reg;
    logic [7:0] ret_cnt_reg;
    logic ret_pend_reg;
    logic ret_arm_reg;
    logic [7:0] clr_cnt_reg;
    logic clr_pend_reg;
    logic clr_arm_reg;
    logic int_reg;
    logic [7:0] cint_cnt_reg;
    logic cint_pend_reg;
    logic [7:0] iclr_cnt_reg;
    logic iclr_pend_reg;
    logic drop_pend_reg;
    logic raise_pend_reg;
    logic [DATA_W-1:0] word_reg;
    logic word_valid_reg;
    logic accept;
    logic retry_evt;

    // Words are taken only while ready, which excludes the retry condition
    assign accept = write_seen && tx_fifo_ready; // RL12
    assign retry_evt = frame_evt.late_collision_in || frame_evt.coll16 || frame_evt.underflow;

    // **********************************************
    // Transmit sequence
    // **********************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            FTX_IDLE: begin
                if (accept) begin
                    state_next = FTX_WAIT;
                end
            end
            FTX_WAIT: begin
                if (txc_tick && start_cnt_reg == 8'd1) begin
                    state_next = FTX_SEND; // RL2
                end
            end
            FTX_SEND: begin
                if (retry_evt) begin
                    state_next = FTX_HALT;
                end else if (frame_evt.done || frame_evt.carrier_drop) begin
                    state_next = FTX_IDLE;
                end
            end
            FTX_HALT: begin
                // Leaves only once the host has cleared the flag
                if (!retry_reg && !ret_pend_reg && !ret_arm_reg) begin
                    state_next = FTX_IDLE; // RL12
                end
            end
            default: state_next = FTX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            state_reg <= FTX_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Start delay counted in line clock edges; mode is sampled at the first write
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            start_cnt_reg <= 8'd0;
        end else if (state_reg == FTX_IDLE && accept) begin
            start_cnt_reg <= pick(mii_mode, `FTX_START_SER, `FTX_START_MII); // RL2
        end else if (txc_tick && start_cnt_reg != 8'd0) begin
            start_cnt_reg <= start_cnt_reg - 8'd1;
        end
    end

    // **********************************************
    // Data capture
    // **********************************************
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            word_reg <= '0;
            word_valid_reg <= 1'b0;
        end else begin
            word_valid_reg <= accept;
            if (accept) begin
                word_reg <= pins_s[`FTX_PIN_DATA +: DATA_W];
            end
        end
    end

    // **********************************************
    // Retry set path
    // **********************************************
    // Exception starts a line-clock countdown; expiry arms the set for a host edge
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ret_cnt_reg <= 8'd0;
            ret_pend_reg <= 1'b0;
            ret_arm_reg <= 1'b0;
        end else begin
            if (state_reg == FTX_SEND && frame_evt.underflow) begin
                ret_cnt_reg <= pick(mii_mode, `FTX_UFLRET_SER, `FTX_UFLRET_MII); // RL4
                ret_pend_reg <= 1'b1;
            end else if (state_reg == FTX_SEND && retry_evt) begin
                ret_cnt_reg <= pick(mii_mode, `FTX_COLLRET_SER, `FTX_COLLRET_MII); // RL3
                ret_pend_reg <= 1'b1;
            end else if (ret_pend_reg && txc_tick) begin
                ret_cnt_reg <= ret_cnt_reg - 8'd1;
                if (ret_cnt_reg == 8'd1) begin
                    ret_pend_reg <= 1'b0;
                    ret_arm_reg <= 1'b1;
                end
            end
            if (ret_arm_reg && hclk_tick) begin
                ret_arm_reg <= 1'b0;
            end
        end
    end

    // **********************************************
    // Retry clear path
    // **********************************************
    // Clear is taken at a host edge, waits one line clock, then applies at a host edge
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            clr_cnt_reg <= 8'd0;
            clr_pend_reg <= 1'b0;
            clr_arm_reg <= 1'b0;
        end else begin
            if (hclk_tick && pins_s[`FTX_PIN_CLR] && retry_reg && !clr_pend_reg) begin
                clr_cnt_reg <= `FTX_ONE_TICK; // RL1
                clr_pend_reg <= 1'b1;
            end else if (clr_pend_reg && txc_tick) begin
                clr_cnt_reg <= clr_cnt_reg - 8'd1;
                if (clr_cnt_reg == 8'd1) begin
                    clr_pend_reg <= 1'b0;
                    clr_arm_reg <= 1'b1;
                end
            end
            if (clr_arm_reg && hclk_tick) begin
                clr_arm_reg <= 1'b0;
            end
        end
    end

    // Flag moves only at host clock edges; a set in the same edge beats the clear
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            retry_reg <= 1'b0;
        end else if (hclk_tick) begin // RL10
            if (ret_arm_reg) begin
                retry_reg <= 1'b1; // RL3 RL4
            end else if (clr_arm_reg) begin
                retry_reg <= 1'b0; // RL1
            end
        end
    end

    // Ready is combinational; it falls as soon as the set is armed, before the flag rises, and returns with the flag
    assign tx_fifo_ready = !retry_reg && !ret_arm_reg; // RL5 RL6

    // **********************************************
    // Transmit enable
    // **********************************************
    // Underflow holds enable one more line clock; other endings drop it at once
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            line_transmit_enable <= 1'b0;
            drop_pend_reg <= 1'b0;
        end else begin
            if (state_reg == FTX_WAIT && state_next == FTX_SEND) begin
                line_transmit_enable <= 1'b1; // RL2
            end else if (state_reg == FTX_SEND && frame_evt.underflow) begin
                drop_pend_reg <= 1'b1; // RL7
            end else if (state_reg == FTX_SEND && (retry_evt || state_next == FTX_IDLE)) begin
                line_transmit_enable <= 1'b0; // RL8
            end else if (drop_pend_reg && txc_tick) begin
                drop_pend_reg <= 1'b0;
                line_transmit_enable <= 1'b0; // RL7
            end
        end
    end

    // **********************************************
    // Interrupt
    // **********************************************
    // Collision countdown starts when the pin rises during a frame and no countdown is pending
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cint_cnt_reg <= 8'd0;
            cint_pend_reg <= 1'b0;
        end else if (collision_in_rise && line_transmit_enable && !cint_pend_reg) begin
            cint_cnt_reg <= pick(mii_mode, `FTX_COLLINT_SER, `FTX_COLLINT_MII); // RL9
            cint_pend_reg <= 1'b1;
        end else if (cint_pend_reg && txc_tick) begin
            cint_cnt_reg <= cint_cnt_reg - 8'd1;
            if (cint_cnt_reg == 8'd1) begin
                cint_pend_reg <= 1'b0;
            end
        end
    end

    // Good end and carrier dropout raise the interrupt one line clock after enable drops
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            raise_pend_reg <= 1'b0;
        end else if (state_reg == FTX_SEND && !retry_evt
                     && (frame_evt.done || frame_evt.carrier_drop)) begin
            raise_pend_reg <= 1'b1; // RL8
        end else if (raise_pend_reg && txc_tick) begin
            raise_pend_reg <= 1'b0;
        end
    end

    // Acknowledge starts a two line clock clear delay
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            iclr_cnt_reg <= 8'd0;
            iclr_pend_reg <= 1'b0;
        end else if (ack_rise && int_reg && !iclr_pend_reg) begin
            iclr_cnt_reg <= `FTX_INTCLR_TICKS; // RL13
            iclr_pend_reg <= 1'b1;
        end else if (iclr_pend_reg && txc_tick) begin
            iclr_cnt_reg <= iclr_cnt_reg - 8'd1;
            if (iclr_cnt_reg == 8'd1) begin
                iclr_pend_reg <= 1'b0;
            end
        end
    end

    // Sticky interrupt; any new cause in the clearing cycle keeps it set
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            int_reg <= 1'b0;
        end else if (state_reg == FTX_SEND && frame_evt.underflow) begin
            int_reg <= 1'b1; // RL7
        end else if (raise_pend_reg && txc_tick) begin
            int_reg <= 1'b1; // RL8
        end else if (cint_pend_reg && txc_tick && cint_cnt_reg == 8'd1) begin
            int_reg <= 1'b1; // RL9
        end else if (iclr_pend_reg && txc_tick && iclr_cnt_reg == 8'd1) begin
            int_reg <= 1'b0; // RL13
        end
    end

    assign tx_retry_flag = retry_reg;
    assign tx_interrupt = int_reg;
    assign tx_word_out = word_reg;
    assign tx_word_valid = word_valid_reg;

endmodule
`default_nettype wire

// ### hdl/ftx_pin_sync.sv
// Two-stage synchroniser with rising-edge detect for a vector of pins
`timescale 1ns/10ps
`default_nettype none

module ftx_pin_sync #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] pin_sync,
    output logic [W-1:0] pin_rise
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] last_reg;

    // **********************************************
    // Synchroniser stages
    // **********************************************
    // First stage is read only by the second stage
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    // Edge detect works on the settled stages only
    assign pin_sync = sync_reg;
    assign pin_rise = sync_reg & ~last_reg;

endmodule
`default_nettype wire

// ### hdl/ftx_pkg.sv
// Types shared by the transmit exception signalling block
package ftx_pkg;

    // Transmit sequence, Gray coded along idle, wait, send, retry
    typedef enum logic [1:0] {
        FTX_IDLE = 2'b00,
        FTX_WAIT = 2'b01,
        FTX_SEND = 2'b11,
        FTX_HALT = 2'b10
    } ftx_state_t;

    // Frame events reported by the transmit core on the same clock
    typedef struct packed {
        logic late_collision_in;
        logic coll16;
        logic underflow;
        logic done;
        logic carrier_drop;
    } ftx_evt_t;

endpackage

// ### hdl/ftx_regs.svh
// Timing counts and field positions for the transmit exception signalling block
`ifndef FTX_REGS_SVH
`define FTX_REGS_SVH

// Line-clock edges from the first accepted write to transmit enable
`define FTX_START_SER 8'd20
`define FTX_START_MII 8'd7
// Line-clock edges from late or sixteenth collision to retry arm
`define FTX_COLLRET_SER 8'd26
`define FTX_COLLRET_MII 8'd8
// Line-clock edges from underflow to retry arm
`define FTX_UFLRET_SER 8'd8
`define FTX_UFLRET_MII 8'd2
// Line-clock edges from collision input to interrupt
`define FTX_COLLINT_SER 8'd21
`define FTX_COLLINT_MII 8'd8
// Line-clock edges for the retry clear and interrupt clear sequences
`define FTX_ONE_TICK 8'd1
`define FTX_INTCLR_TICKS 8'd2
// Bit positions in the synchronised pin vector
`define FTX_PIN_TXC 0
`define FTX_PIN_HCLK 1
`define FTX_PIN_COLLISION_IN 2
`define FTX_PIN_CLR 3
`define FTX_PIN_SEL_N 4
`define FTX_PIN_WR_N 5
`define FTX_PIN_ACK 6
`define FTX_PIN_DATA 7

`endif
